// ### sdp_ahb_cfg.sv
// ahb-lite slave holding the board settings
`timescale 1ns/10ps
module sdp_ahb_cfg import sdp_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [31:0] stat,
  input wire logic [CH_N*CODE_W-1:0] codes,
  output logic [7:0] base_sw_on,
  output logic [1:0] am_sel,
  output logic [2:0] dly_sel,
  output logic [1:0] coding
);
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic take;
  logic [31:0] cfg_word;
  logic [31:0] rd_nxt;
  int idx;

  assign take = hsel && hready && htrans[1];
  assign cfg_word = {17'h0_0000, coding, dly_sel, am_sel, base_sw_on};

  always_comb begin
    idx = 0;
    rd_nxt = 32'h0000_0000;
    if (haddr[7:0] == REG_CFG) begin
      rd_nxt = cfg_word;
    end else if (haddr[7:0] == REG_STAT) begin
      rd_nxt = stat;
    end else if (haddr[7:0] >= REG_CH0 && haddr[7:0] < REG_CH0 + 8'(4 * CH_N)) begin
      idx = int'(haddr[7:2] - REG_CH0[7:2]);
      rd_nxt = {20'h0_0000, codes[idx*CODE_W +: CODE_W]};
    end
  end

  // zero wait states; hsize ignored, only whole words are expected
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take) begin
        wr_addr_r <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_sw_on <= BASE_SW_ON_RST;
      am_sel <= AM_SEL_RST;
      dly_sel <= DLY_SEL_RST;
      coding <= CODING_RST;
    end else if (wr_pend_r && wr_addr_r == REG_CFG) begin
      base_sw_on <= hwdata[CFG_SW_LSB +: 8];
      am_sel <= hwdata[CFG_AM_LSB +: 2];
      dly_sel <= hwdata[CFG_DLY_LSB +: 3];
      coding <= hwdata[CFG_COD_LSB +: 2];
    end
  end
endmodule // sdp_ahb_cfg

// ### sdp_dac_port.sv
// short i/o bus slave front end of the four-channel dac board
`timescale 1ns/10ps
module sdp_dac_port import sdp_pkg::*; #(
  parameter logic [7:0] ID_BYTE = 8'h5A // arbitrary identification value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sysclk,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic write_n,
  input wire logic [5:0] am,
  input wire logic [23:1] vaddr,
  input wire logic [15:0] vdata_in,
  output logic [15:0] vdata_out,
  output logic vdata_oe,
  output logic dtack_n_out,
  output logic dtack_oe,
  output logic [CH_N*CODE_W-1:0] dac_code,
  output logic [CH_N-1:0] dac_load
);
  typedef enum logic [1:0] {SDP_IDLE, SDP_WAIT, SDP_ACK} sdp_state_t;

  sdp_state_t state_r;
  logic [7:0] base_sw_on;
  logic [1:0] am_sel;
  logic [2:0] dly_sel;
  logic [31:0] stat;
  logic sysclk_q_r;
  logic sys_rise;
  logic [4:0] tick_cnt_r;
  logic [4:0] tick_goal;
  logic [7:0] base_val;
  logic am_ok;
  logic hit;
  logic ds_any;
  logic ds_none;
  logic [7:0] off_r;
  logic is_wr_r;
  logic ds0_r;
  logic ds1_r;
  logic [15:0] wdata_r;
  logic sysclk_seen_r;
  logic [7:0] ack_count_r;
  logic cyc_start;
  logic delay_done;

  sdp_ahb_cfg u_cfg (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .stat(stat),
    .codes(dac_code),
    .base_sw_on(base_sw_on),
    .am_sel(am_sel),
    .dly_sel(dly_sel),
    // zero code at reset follows the reset coding, so the live coding is unused here
    .coding()
  );

  assign stat = {22'h00_0000, ack_count_r, sysclk_seen_r, state_r != SDP_IDLE};

  // closed position reads as 0 on the comparator
  assign base_val = ~base_sw_on;

  always_comb begin
    am_ok = 1'b0;
    case (am_sel)
      SDP_AM_SIO_ANY: am_ok = (am == AM_SIO_USER) || (am == AM_SIO_SUP);
      SDP_AM_SIO_SUP: am_ok = (am == AM_SIO_SUP);
      SDP_AM_STD_ANY: am_ok = (am == AM_STD_USER) || (am == AM_STD_SUP);
      default: am_ok = (am == AM_STD_SUP);
    endcase
  end

  // upper lines 23..16 never enter the compare
  assign hit = am_ok && (vaddr[15:8] == base_val);
  assign ds_any = !ds0_n || !ds1_n;
  assign ds_none = ds0_n && ds1_n;
  // a cycle is claimed only with a strobe down and a full match
  assign cyc_start = !as_n && ds_any && hit;

  // sysclk is slower than clock, so edges are seen one at a time
  assign sys_rise = sysclk && !sysclk_q_r;
  assign tick_goal = sdp_dly_ticks(dly_sel);
  assign delay_done = sys_rise && tick_cnt_r + 5'h01 >= tick_goal;

  // tracks the pin in reset too, so release never shows a false rise
  always_ff @(posedge clock) begin
    sysclk_q_r <= sysclk;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sysclk_seen_r <= 1'b0;
    end else if (sys_rise) begin
      sysclk_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= SDP_IDLE;
    end else begin
      case (state_r)
        SDP_IDLE: begin
          if (cyc_start) begin
            state_r <= SDP_WAIT;
          end
        end
        SDP_WAIT: begin
          if (as_n || ds_none) begin
            state_r <= SDP_IDLE;
          end else if (delay_done) begin
            state_r <= SDP_ACK;
          end
        end
        default: begin
          if (ds_none) begin
            state_r <= SDP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt_r <= 5'h00;
    end else if (state_r != SDP_WAIT) begin
      tick_cnt_r <= 5'h00;
    end else if (sys_rise) begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
    end
  end

  // cycle attributes captured once the slave is selected
  always_ff @(posedge clock) begin
    if (rst) begin
      off_r <= 8'h00;
      is_wr_r <= 1'b0;
      ds0_r <= 1'b0;
      ds1_r <= 1'b0;
      wdata_r <= 16'h0000;
    end else if (state_r == SDP_IDLE && cyc_start) begin
      off_r <= {vaddr[7:1], 1'b0};
      is_wr_r <= !write_n;
      ds0_r <= !ds0_n;
      ds1_r <= !ds1_n;
      wdata_r <= vdata_in;
    end
  end

  logic ack_go;
  logic ch_sel;
  logic [1:0] ch_idx;
  assign ack_go = state_r == SDP_WAIT && !as_n && !ds_none && delay_done;
  // offsets above the four channels mirror them in 8-byte groups
  assign ch_sel = off_r >= CH_BASE_OFF;
  assign ch_idx = off_r[2:1];

  logic ack_drop;
  // release once both strobes are seen high, or the cycle is gone
  assign ack_drop = state_r != SDP_ACK || ds_none;

  always_ff @(posedge clock) begin
    if (rst) begin
      dtack_n_out <= 1'b1;
      dtack_oe <= 1'b0;
    end else if (ack_go) begin
      dtack_n_out <= 1'b0;
      dtack_oe <= 1'b1;
    end else if (ack_drop) begin
      dtack_n_out <= 1'b1;
      dtack_oe <= 1'b0;
    end
  end

  // read data drives only while the acknowledge stands
  always_ff @(posedge clock) begin
    if (rst) begin
      vdata_oe <= 1'b0;
      vdata_out <= 16'h0000;
    end else if (ack_go) begin
      vdata_oe <= !is_wr_r;
      vdata_out <= (off_r < ID_END_OFF) ? {8'h00, ID_BYTE} : 16'h0000;
    end else if (ack_drop) begin
      vdata_oe <= 1'b0;
    end
  end

  // status only; wraps to 0 on the 256th acknowledged cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_count_r <= 8'h00;
    end else if (ack_go) begin
      ack_count_r <= ack_count_r + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      logic wr_me;
      assign wr_me = ack_go && is_wr_r && ch_sel && ch_idx == 2'(g);
      always_ff @(posedge clock) begin
        if (rst) begin
          dac_code[g*CODE_W +: CODE_W] <= sdp_zero_code(CODING_RST);
          dac_load[g] <= 1'b1;
        end else begin
          dac_load[g] <= wr_me;
          if (wr_me && ds1_r) begin
            dac_code[g*CODE_W+CODE_LSB +: 8] <= wdata_r[15:8];
          end
          if (wr_me && ds0_r) begin
            dac_code[g*CODE_W +: CODE_LSB] <= wdata_r[7:4];
          end
        end
      end
    end
  endgenerate
endmodule // sdp_dac_port

// ### sdp_dac_port_sva.sv
// assertions on the bus-slave pins of the dac port
`timescale 1ns/10ps
module sdp_dac_port_sva import sdp_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic sysclk,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic write_n,
  input wire logic [5:0] am,
  input wire logic [15:0] vdata_in,
  input wire logic dtack_n_out,
  input wire logic dtack_oe,
  input wire logic [CH_N*CODE_W-1:0] dac_code,
  input wire logic [CH_N-1:0] dac_load
);
  logic sys_r;
  logic [4:0] tick_r;
  // sysclk rises while a cycle waits; saturates so a hung cycle cannot wrap
  always_ff @(posedge clock) begin
    sys_r <= sysclk;
    if (rst || as_n) begin
      tick_r <= 5'h00;
    end else if (sysclk && !sys_r && !dtack_oe && tick_r != 5'h1F) begin
      tick_r <= tick_r + 5'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_ack_up;
    $rose(dtack_oe);
  endsequence
  sequence s_ds_up;
    dtack_oe && ds0_n && ds1_n;
  endsequence
  AST_ACK_CAUSE: assert property (s_ack_up |-> !as_n && !(ds0_n && ds1_n)
    && am[5] && am[3] && am[1:0] == 2'h1) else $error("ack without cycle");
  AST_ACK_DELAY: assert property (s_ack_up |-> tick_r >= 5'h03 && tick_r <= 5'h12)
    else $error("ack delay");
  AST_ACK_LOW: assert property (dtack_oe |-> !dtack_n_out) else $error("ack level");
  AST_ACK_DROP: assert property (s_ds_up |=> !dtack_oe) else $error("ack release");
  AST_LOAD_ONE: assert property (!$past(rst) && dac_load != '0 |-> $onehot(dac_load))
    else $error("load pulse");
  AST_LOAD_CAUSE: assert property (!$past(rst) && dac_load != '0 |-> s_ack_up ##0 !write_n)
    else $error("load cause");
  AST_CODE_HOLD: assert property (!$past(rst) && dac_load == '0 |-> $stable(dac_code))
    else $error("code moved");
  AST_LOAD_CODE: assert property (!$past(rst) && dac_load[0] && !ds0_n && !ds1_n
    |-> dac_code[CODE_W-1:0] == vdata_in[15:CODE_LSB]) else $error("code bits");
endmodule // sdp_dac_port_sva

// ### sdp_pkg.sv
// shared constants for the short i/o dac port slave
package sdp_pkg;
  localparam int CH_N = 4;
  localparam int CODE_W = 12;
  localparam int CODE_LSB = 4;
  localparam int OFF_W = 8;
  localparam logic [7:0] BASE_SW_ON_RST = 8'h36;
  localparam logic [5:0] AM_SIO_USER = 6'h29;
  localparam logic [5:0] AM_SIO_SUP = 6'h2D;
  localparam logic [5:0] AM_STD_USER = 6'h39;
  localparam logic [5:0] AM_STD_SUP = 6'h3D;
  typedef enum logic [1:0] {
    SDP_AM_SIO_ANY,
    SDP_AM_SIO_SUP,
    SDP_AM_STD_ANY,
    SDP_AM_STD_SUP
  } sdp_am_sel_t;
  typedef enum logic [1:0] {
    SDP_COD_UNI_BIN,
    SDP_COD_OFF_BIN,
    SDP_COD_TWOS
  } sdp_coding_t;
  localparam logic [1:0] AM_SEL_RST = 2'h0;
  localparam logic [2:0] DLY_SEL_RST = 3'h1;
  localparam logic [1:0] CODING_RST = 2'h2;
  localparam int SYSCLK_PERIOD_NS = 62;
  localparam int DLY_STEP_NS = 125;
  localparam logic [7:0] CH_BASE_OFF = 8'hA0;
  localparam logic [7:0] ID_END_OFF = 8'h80;
  localparam logic [11:0] ZERO_UNI = 12'h000;
  localparam logic [11:0] ZERO_OFF = 12'h800;
  localparam logic [11:0] ZERO_TWOS = 12'h000;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CH0 = 8'h10;
  localparam int CFG_SW_LSB = 0;
  localparam int CFG_AM_LSB = 8;
  localparam int CFG_DLY_LSB = 10;
  localparam int CFG_COD_LSB = 13;
  // sysclk periods for a delay selection, rounded up
  function automatic logic [4:0] sdp_dly_ticks(input logic [2:0] sel);
    int ns;
    ns = (int'(sel) + 1) * DLY_STEP_NS;
    return 5'((ns + SYSCLK_PERIOD_NS - 1) / SYSCLK_PERIOD_NS);
  endfunction
  function automatic logic [11:0] sdp_zero_code(input logic [1:0] cod);
    if (cod == SDP_COD_OFF_BIN) begin
      return ZERO_OFF;
    end else if (cod == SDP_COD_UNI_BIN) begin
      return ZERO_UNI;
    end
    return ZERO_TWOS;
  endfunction
endpackage

// ### sdp_vme_host.sv
// bus master model in the host's place
`timescale 1ns/10ps
module sdp_vme_host #(
  parameter int HALF_NS = 80 // slower than 62 ns so a 40 ns clock sees every rise
) (
  input wire logic clock,
  input wire logic [15:0] vdata_out,
  input wire logic vdata_oe,
  input wire logic dtack_n_out,
  input wire logic dtack_oe,
  output logic sysclk,
  output logic as_n,
  output logic ds0_n,
  output logic ds1_n,
  output logic write_n,
  output logic [5:0] am,
  output logic [23:1] vaddr,
  output logic [15:0] vdata_in
);
  logic run = 1'h1;
  int rises = 0;
  initial begin
    sysclk = 1'h0;
    {as_n, ds0_n, ds1_n, write_n} = 4'hF;
    am = 6'h00;
    vaddr = 23'h00_0000;
    vdata_in = 16'h0000;
  end
  always #(HALF_NS) sysclk = run ? !sysclk : 1'h0;
  always @(posedge sysclk) rises++;
  // undriven data shows the inverse of the last value
  task automatic cycle(input logic wr, input logic [5:0] mod, input logic [23:0] a,
      input logic [15:0] wd, output logic ack, output logic [15:0] rdat, output int ticks);
    int t0;
    t0 = rises;
    ack = 1'h0;
    rdat = 16'h0000;
    {as_n, ds0_n, ds1_n, write_n} <= {3'h0, !wr};
    am <= mod;
    vaddr <= a[23:1];
    vdata_in <= wr ? wd : ~vdata_in;
    for (int i = 0; i < 120 && !ack; i++) begin
      @(posedge clock);
      if (dtack_oe && !dtack_n_out) begin
        ack = 1'h1;
        rdat = vdata_oe ? vdata_out : ~vdata_out;
      end
    end
    ticks = rises - t0;
    {as_n, ds0_n, ds1_n} <= 3'h7;
    vdata_in <= ~vdata_in;
    repeat (2) @(posedge clock);
  endtask
endmodule // sdp_vme_host

// ### tb.sv
// self-checking bench for the dac port
`timescale 1ns/10ps
module tb import sdp_pkg::*;;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd;
  wire hready, hreadyout, hresp, sysclk, as_n, ds0_n, ds1_n;
  wire write_n, vdata_oe, dtack_n_out, dtack_oe;
  wire [31:0] hrdata;
  wire [5:0] am;
  wire [23:1] vaddr;
  wire [15:0] vdata_in, vdata_out;
  wire [CH_N*CODE_W-1:0] dac_code;
  wire [CH_N-1:0] dac_load;
  logic ack;
  logic [15:0] vd;
  int tk, n, err_count = 0, n_compared = 0;
  logic [3:0] acc [4] = '{4'h3, 4'h2, 4'hC, 4'h8};
  assign hready = hreadyout;
  always #20 clock = ~clock;
  sdp_dac_port #(.ID_BYTE(8'hC3)) sdp_dac_port_i (.*); // id value is arbitrary
  sdp_vme_host sdp_vme_host_i (.*);
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic hw();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (hreadyout === 1'h1) break;
    end
    if (i == 50) begin
      chk(1'h0, "bus timeout");
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    {hsel, htrans, haddr, hwrite} <= {3'h6, a, w};
    hw();
    {hsel, htrans, hwdata} <= {3'h0, d};
    hw();
    rd = hrdata;
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] sw, input logic [1:0] a,
      input logic [2:0] d);
    return 32'(sw) << CFG_SW_LSB | 32'(a) << CFG_AM_LSB | 32'(d) << CFG_DLY_LSB
      | 32'h0000_0002 << CFG_COD_LSB;
  endfunction
  task automatic vc(input logic w, input logic [5:0] m, input logic [23:0] a,
      input logic [15:0] d);
    sdp_vme_host_i.cycle(w, m, a, d, ack, vd, tk);
  endtask
  initial begin
    {hsel, hwrite, htrans, hsize} = 7'h02;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    chk(dac_code === '0 && dtack_oe === 1'h0 && vdata_oe === 1'h0 && hresp === 1'h0, "reset state");
    ahb(1'h0, 32'h0000_0040, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "unmapped read");
    ahb(1'h0, 32'(REG_CFG), 32'h0000_0000);
    chk(rd === cfg(~8'hC9, 2'h0, 3'h1), "defaults");
    vc(1'h1, AM_SIO_USER, 24'hA5_C9A0, 16'hABCD);
    chk(ack === 1'h1 && dac_code[11:0] === 12'hABC, "ch0 write");
    for (int s = 0; s < 8; s++) begin
      ahb(1'h1, 32'(REG_CFG), cfg(~8'hC9, 2'h0, 3'(s)));
      vc(1'h1, AM_SIO_SUP, 24'h00_C9A2, 16'h0230 | 16'(s) << 12);
      n = ((s + 1) * DLY_STEP_NS + SYSCLK_PERIOD_NS - 1) / SYSCLK_PERIOD_NS;
      chk(ack === 1'h1 && tk >= n && tk <= n + 1, "ack delay");
      chk(dac_code[23:12] === {4'(s), 8'h23}, "ch1 write");
    end
    // modifier code built as 29, 2d, 39, 3d from the loop index
    for (int s = 0; s < 4; s++) begin
      ahb(1'h1, 32'(REG_CFG), cfg(~8'hC9, 2'(s), 3'h1));
      for (int m = 0; m < 4; m++) begin
        vc(1'h1, {1'h1, m[1], 1'h1, m[0], 2'h1}, 24'h00_C9A4, 16'h0000);
        chk(ack === acc[s][m], "modifier set");
      end
    end
    ahb(1'h1, 32'(REG_CFG), cfg(~8'h12, 2'h0, 3'h1));
    vc(1'h1, AM_SIO_USER, 24'h00_C9A6, 16'hFFF0);
    chk(ack === 1'h0, "old base");
    vc(1'h1, AM_SIO_USER, 24'h00_12AA, 16'h5670);
    chk(ack === 1'h1 && dac_code[23:12] === 12'h567, "mirror ch1");
    vc(1'h0, AM_SIO_USER, 24'h00_1200, 16'h0000);
    chk(ack === 1'h1 && vd === 16'h00C3, "id read");
    sdp_vme_host_i.run = 1'h0;
    vc(1'h1, AM_SIO_USER, 24'h00_12A0, 16'h0000);
    chk(ack === 1'h0 && dac_code[11:0] === 12'hABC, "no sysclk");
    // 17 acknowledged cycles so far, sysclk seen, slave idle
    ahb(1'h0, 32'(REG_STAT), 32'h0000_0000);
    chk(rd === 32'h0000_0046, "status");
    ahb(1'h0, 32'(REG_CH0) + 32'h0000_0004, 32'h0000_0000);
    chk(rd === 32'h0000_0567, "ch1 readback");
    report_and_stop();
  end
endmodule // tb
bind sdp_dac_port sdp_dac_port_sva sdp_dac_port_sva_i (.*);
